// File: dmda_core.sv
// data space decoder and memory access sequencer
// assumes the load/store pipeline holds a request until done, and that the
// register file and i/o blocks answer combinationally on their buses
`timescale 1ns/100ps
`default_nettype none
module dmda_core #(
  parameter int unsigned SRAM_BYTES = dmda_pkg::SRAM_BYTES,
  parameter int unsigned NVM_BYTES  = dmda_pkg::NVM_BYTES,
  parameter int unsigned PC_WIDTH   = dmda_pkg::PC_WIDTH,
  parameter int unsigned ATOMIC_CYC = dmda_pkg::PROG_ATOMIC_CYC,
  parameter int unsigned SPLIT_CYC  = dmda_pkg::PROG_SPLIT_CYC
) (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire dmda_pkg::dmda_req_t       REQ,
  input  wire logic [7:0]                REG_RDATA,
  input  wire logic [7:0]                IO_RDATA,
  output dmda_pkg::dmda_rsp_t            RSP,
  output logic                           REG_WE,
  output logic                           IO_WE,
  output logic                           IO_RE,
  output logic [7:0]                     SEL_ADDR,
  output logic [7:0]                     SEL_WDATA,
  output logic                           STALL,
  output logic                           NVM_BUSY,
  output logic                           ACCESS_FAULT,
  output logic [PC_WIDTH-1:0]            PROG_WORD_ADDR_MAX
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam logic [15:0] SRAM_END = 16'(dmda_pkg::SRAM_BASE + SRAM_BYTES);

  // region of a data space address
  function automatic dmda_pkg::dmda_region_t region_of(input logic [15:0] a);
    if (a < dmda_pkg::STDIO_BASE) begin
      return dmda_pkg::DMDA_REG_FILE;
    end else if (a < dmda_pkg::EXTIO_BASE) begin
      return dmda_pkg::DMDA_REG_STD;
    end else if (a < dmda_pkg::SRAM_BASE) begin
      return dmda_pkg::DMDA_REG_EXT;
    end else if (a < SRAM_END) begin
      return dmda_pkg::DMDA_REG_SRAM;
    end else begin
      return dmda_pkg::DMDA_REG_NONE;
    end
  endfunction

  // ****************************************************************
  // address generation
  // ****************************************************************
  wire logic [15:0] ptr_dec   = REQ.ptr - 16'h0001;
  wire logic [15:0] ptr_inc   = REQ.ptr + 16'h0001;
  wire logic [15:0] disp_addr = REQ.ptr + {10'h000, REQ.disp};
  wire logic [15:0] port_addr = REQ.addr + dmda_pkg::STDIO_BASE;
  wire logic        port_bad  = REQ.port_op && (REQ.addr > 16'h003f);
  logic [15:0]      eff_addr;

  // effective address per addressing mode
  always_comb begin
    if (REQ.port_op) begin
      eff_addr = port_addr;
    end else begin
      case (REQ.mode)
        dmda_pkg::DMDA_MODE_DIRECT: eff_addr = REQ.addr;
        dmda_pkg::DMDA_MODE_DISP:   eff_addr = disp_addr;
        dmda_pkg::DMDA_MODE_PREDEC: eff_addr = ptr_dec;
        default:                    eff_addr = REQ.ptr;
      endcase
    end
  end

  wire dmda_pkg::dmda_region_t region = region_of(eff_addr);
  wire logic [5:0] io_port = 6'(eff_addr - dmda_pkg::STDIO_BASE);
  wire logic is_io  = (region == dmda_pkg::DMDA_REG_STD) || (region == dmda_pkg::DMDA_REG_EXT);
  // nvm registers live in standard i/o
  wire logic hit_ctrl  = (region == dmda_pkg::DMDA_REG_STD) && (io_port == dmda_pkg::NVM_CTRL_PORT);
  wire logic hit_data  = (region == dmda_pkg::DMDA_REG_STD) && (io_port == dmda_pkg::NVM_DATA_PORT);
  wire logic hit_addrl = (region == dmda_pkg::DMDA_REG_STD) && (io_port == dmda_pkg::NVM_ADDRL_PORT);
  wire logic hit_addrh = (region == dmda_pkg::DMDA_REG_STD) && (io_port == dmda_pkg::NVM_ADDRH_PORT);
  wire logic hit_nvm   = hit_ctrl | hit_data | hit_addrl | hit_addrh;

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  typedef enum logic [1:0] {
    DMDA_ST_IDLE  = 2'b00,
    DMDA_ST_SRAM  = 2'b01,
    DMDA_ST_STALL = 2'b10
  } dmda_state_t;

  dmda_state_t state;       // current state
  dmda_state_t next_state;  // next state
  logic [2:0]  stall_cnt;   // stall cycles left
  logic [7:0]  sram_mem [SRAM_BYTES];  // internal sram
  logic [7:0]  nvm_mem  [NVM_BYTES];   // nvm byte array
  logic [7:0]  sram_q;      // sram read data
  logic [8:0]  nvm_addr;    // nvm address register
  logic [7:0]  nvm_data;    // nvm data register
  logic [1:0]  nvm_mode;    // programming mode
  logic        nvm_arm;     // master write enable
  logic [2:0]  arm_cnt;     // arm window countdown
  logic        nvm_write_strobe;  // write strobe, busy while set

  wire logic [7:0] ctrl_rd = {2'h0, nvm_mode, 1'b0, nvm_arm, nvm_write_strobe, 1'b0};
  wire logic       accept  = REQ.valid && !RSP.done && (state == DMDA_ST_IDLE) && !port_bad;
  wire logic       wr_ctrl = accept && REQ.write && hit_ctrl;
  wire logic       rd_go   = wr_ctrl && REQ.wdata[dmda_pkg::CTRL_READ_BIT] && !nvm_write_strobe;
  // arm bit must be live for the strobe to count
  wire logic       wr_go   = wr_ctrl && REQ.wdata[dmda_pkg::CTRL_WRITE_BIT] && nvm_arm
                             && !nvm_write_strobe && !rd_go;
  wire logic       tmr_busy;
  wire logic       tmr_finish;

  // self-timed programming counter
  dmda_nvm_timer #(
    .ATOMIC_CYC (ATOMIC_CYC),
    .SPLIT_CYC  (SPLIT_CYC)
  ) u_timer (
    .clk    (CLK),
    .start  (wr_go),
    .mode   (nvm_mode),
    .busy   (tmr_busy),
    .finish (tmr_finish)
  );

  // next state selection
  always_comb begin
    next_state = state;
    case (state)
      DMDA_ST_IDLE: begin
        if (accept && region == dmda_pkg::DMDA_REG_SRAM) begin
          next_state = DMDA_ST_SRAM;
        end else if (rd_go || wr_go) begin
          next_state = DMDA_ST_STALL;
        end
      end
      DMDA_ST_SRAM:  next_state = DMDA_ST_IDLE;
      default: begin
        if (stall_cnt == 3'h1) begin
          next_state = DMDA_ST_IDLE;
        end
      end
    endcase
  end

  // state register and stall counter
  always_ff @(posedge CLK) begin
    if (RST) begin
      state     <= DMDA_ST_IDLE;
      stall_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (rd_go) begin
        stall_cnt <= 3'(dmda_pkg::NVM_RD_STALL);
      end else if (wr_go) begin
        stall_cnt <= 3'(dmda_pkg::NVM_WR_STALL);
      end else if (stall_cnt != 3'h0) begin
        stall_cnt <= stall_cnt - 3'h1;
      end
    end
  end

  // ****************************************************************
  // sram array
  // ****************************************************************
  wire logic [15:0] sram_off = eff_addr - dmda_pkg::SRAM_BASE;

  // first cycle of a two-cycle sram access
  always_ff @(posedge CLK) begin
    if (accept && region == dmda_pkg::DMDA_REG_SRAM) begin
      if (REQ.write) begin
        sram_mem[sram_off[$clog2(SRAM_BYTES)-1:0]] <= REQ.wdata;
      end
      sram_q <= sram_mem[sram_off[$clog2(SRAM_BYTES)-1:0]];
    end
  end

  // ****************************************************************
  // nvm registers
  // ****************************************************************
  // mode bits hold through reset while programming
  always_ff @(posedge CLK) begin
    if (RST && !tmr_busy) begin
      nvm_mode <= dmda_pkg::MODE_RESET;
    end else if (wr_ctrl && !nvm_write_strobe) begin
      nvm_mode <= REQ.wdata[dmda_pkg::CTRL_MODE_LSB +: 2];
    end
  end

  // arm bit clears itself after four cycles
  always_ff @(posedge CLK) begin
    if (RST) begin
      nvm_arm <= 1'b0;
      arm_cnt <= 3'h0;
    end else if (wr_ctrl && REQ.wdata[dmda_pkg::CTRL_ARM_BIT]) begin
      nvm_arm <= 1'b1;
      arm_cnt <= 3'(dmda_pkg::ARM_WINDOW);
    end else if (arm_cnt > 3'h1) begin
      arm_cnt <= arm_cnt - 3'h1;
    end else begin
      nvm_arm <= 1'b0;
      arm_cnt <= 3'h0;
    end
  end

  // strobe follows the timer, so reset cannot drop it
  assign nvm_write_strobe = tmr_busy;

  // address and data registers; array write and read
  always_ff @(posedge CLK) begin
    if (accept && REQ.write && hit_addrl) begin
      nvm_addr[7:0] <= REQ.wdata;
    end
    if (accept && REQ.write && hit_addrh) begin
      nvm_addr[8] <= REQ.wdata[0];
    end
    if (accept && REQ.write && hit_data) begin
      nvm_data <= REQ.wdata;
    end else if (rd_go) begin
      nvm_data <= nvm_mem[nvm_addr[$clog2(NVM_BYTES)-1:0]];
    end
    if (wr_go) begin
      case (nvm_mode)
        2'h1:    nvm_mem[nvm_addr[$clog2(NVM_BYTES)-1:0]] <= 8'hff;
        2'h2:    nvm_mem[nvm_addr[$clog2(NVM_BYTES)-1:0]] <= nvm_mem[nvm_addr[$clog2(NVM_BYTES)-1:0]] & nvm_data;
        default: nvm_mem[nvm_addr[$clog2(NVM_BYTES)-1:0]] <= nvm_data;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  wire logic single = accept && region != dmda_pkg::DMDA_REG_SRAM && !rd_go && !wr_go;
  logic [7:0] rd_mux;

  // read data for single-cycle regions
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_data) begin
      rd_mux = nvm_data;
    end else if (hit_addrl) begin
      rd_mux = nvm_addr[7:0];
    end else if (hit_addrh) begin
      rd_mux = {7'h00, nvm_addr[8]};
    end else if (region == dmda_pkg::DMDA_REG_FILE) begin
      rd_mux = REG_RDATA;
    end else if (is_io) begin
      rd_mux = IO_RDATA;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // registered answer; pointer update per mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP          <= '0;
      REG_WE       <= 1'b0;
      IO_WE        <= 1'b0;
      IO_RE        <= 1'b0;
      SEL_ADDR     <= 8'h00;
      SEL_WDATA    <= 8'h00;
      STALL        <= 1'b0;
      NVM_BUSY     <= nvm_write_strobe;  // a running write stays visible
      ACCESS_FAULT <= 1'b0;
    end else begin
      RSP.done <= single || (state == DMDA_ST_SRAM)
                  || (state == DMDA_ST_STALL && stall_cnt == 3'h1);
      if (single) begin
        RSP.rdata <= rd_mux;
      end else if (state == DMDA_ST_SRAM) begin
        RSP.rdata <= sram_q;
      end
      if (accept) begin
        RSP.ptr_we  <= !REQ.port_op && (REQ.mode == dmda_pkg::DMDA_MODE_PREDEC
                       || REQ.mode == dmda_pkg::DMDA_MODE_POSTIN);
        RSP.ptr_new <= (REQ.mode == dmda_pkg::DMDA_MODE_PREDEC) ? ptr_dec : ptr_inc;
      end else begin
        RSP.ptr_we <= 1'b0;
      end
      REG_WE       <= single && REQ.write && region == dmda_pkg::DMDA_REG_FILE;
      IO_WE        <= single && REQ.write && is_io && !hit_nvm;
      IO_RE        <= single && !REQ.write && is_io && !hit_nvm;
      SEL_ADDR     <= eff_addr[7:0];
      SEL_WDATA    <= REQ.wdata;
      STALL        <= (next_state != DMDA_ST_IDLE);
      NVM_BUSY     <= nvm_write_strobe;
      ACCESS_FAULT <= REQ.valid && (port_bad || (state == DMDA_ST_IDLE
                      && region == dmda_pkg::DMDA_REG_NONE));
    end
  end

  // largest program word address for this variant
  always_ff @(posedge CLK) begin
    PROG_WORD_ADDR_MAX <= {PC_WIDTH{1'b1}};
  end

endmodule
`default_nettype wire

// File: dmda_pkg.sv
// package for the data memory decode and access block
// assumes one cpu clock domain at 40 mhz and a synchronous active-high reset
package dmda_pkg;

  // ****************************************************************
  // data space map
  // ****************************************************************
  localparam int unsigned REGFILE_SIZE = 32;   // working registers
  localparam int unsigned STDIO_SIZE   = 64;   // standard i/o block
  localparam int unsigned EXTIO_SIZE   = 160;  // extended i/o block
  localparam logic [15:0] REGFILE_BASE = 16'h0000;
  localparam logic [15:0] STDIO_BASE   = 16'h0020;  // also the port-to-data offset
  localparam logic [15:0] EXTIO_BASE   = 16'h0060;
  localparam logic [15:0] SRAM_BASE    = 16'h0100;
  localparam int unsigned SRAM_BYTES   = 1024;  // 512 on the small variant
  localparam int unsigned NVM_BYTES    = 512;   // 256 on the small variant
  localparam int unsigned PC_WIDTH     = 13;    // 11, 12 or 13 per variant
  localparam int unsigned PROG_WORD    = 16;    // program word width
  localparam logic [5:0]  DISP_MAX     = 6'h3f; // largest displacement

  // ****************************************************************
  // nvm register i/o-port addresses
  // ****************************************************************
  localparam logic [5:0] NVM_CTRL_PORT  = 6'h1f;
  localparam logic [5:0] NVM_DATA_PORT  = 6'h20;
  localparam logic [5:0] NVM_ADDRL_PORT = 6'h21;
  localparam logic [5:0] NVM_ADDRH_PORT = 6'h22;

  // control register bit positions
  localparam int unsigned CTRL_READ_BIT   = 0;
  localparam int unsigned CTRL_WRITE_BIT  = 1;
  localparam int unsigned CTRL_ARM_BIT    = 2;
  localparam int unsigned CTRL_MODE_LSB   = 4;
  localparam logic [1:0]  MODE_RESET      = 2'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SRAM_CYCLES     = 2;
  localparam int unsigned NVM_RD_STALL    = 4;
  localparam int unsigned NVM_WR_STALL    = 2;
  localparam int unsigned ARM_WINDOW      = 4;
  localparam int unsigned PROG_ATOMIC_US  = 3400;  // 3.4 ms
  localparam int unsigned PROG_SPLIT_US   = 1800;  // 1.8 ms
  localparam int unsigned PROG_ATOMIC_CYC = PROG_ATOMIC_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROG_SPLIT_CYC  = PROG_SPLIT_US * (CLK_HZ / 1_000_000);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DMDA_MODE_DIRECT = 2'b00,
    DMDA_MODE_DISP   = 2'b01,
    DMDA_MODE_PREDEC = 2'b10,
    DMDA_MODE_POSTIN = 2'b11
  } dmda_amode_t;

  typedef enum logic [2:0] {
    DMDA_REG_FILE = 3'b000,
    DMDA_REG_STD  = 3'b001,
    DMDA_REG_EXT  = 3'b010,
    DMDA_REG_SRAM = 3'b011,
    DMDA_REG_NONE = 3'b100
  } dmda_region_t;

  // one access request from the load/store pipeline
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        port_op;   // short i/o-port instruction
    dmda_amode_t mode;
    logic [15:0] addr;      // direct address or i/o-port address
    logic [15:0] ptr;       // selected pointer pair value
    logic [5:0]  disp;
    logic [7:0]  wdata;
  } dmda_req_t;

  // answer to the pipeline
  typedef struct packed {
    logic        done;
    logic [7:0]  rdata;
    logic        ptr_we;
    logic [15:0] ptr_new;
  } dmda_rsp_t;

endpackage

// File: dmda_nvm_timer.sv
// self-timed programming counter for the nvm byte array
// assumes start is a one-cycle pulse; keeps counting through reset
`timescale 1ns/100ps
`default_nettype none
module dmda_nvm_timer #(
  parameter int unsigned ATOMIC_CYC = dmda_pkg::PROG_ATOMIC_CYC,
  parameter int unsigned SPLIT_CYC  = dmda_pkg::PROG_SPLIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       start,    // begin a programming cycle
  input  wire logic [1:0] mode,     // programming mode at start
  output logic            busy,     // programming in progress
  output logic            finish    // one-cycle pulse at the end
);

  logic [17:0] count;  // cycles left
  logic        powered; // state known after first clock edge

  // no reset on purpose: a write in progress runs on through reset
  always_ff @(posedge clk) begin
    finish <= 1'b0;
    if (start) begin
      count   <= (mode == 2'h0) ? 18'(ATOMIC_CYC) : 18'(SPLIT_CYC);
      busy    <= 1'b1;
      powered <= 1'b1;
    end else if (powered && busy) begin
      if (count <= 18'h00001) begin
        busy   <= 1'b0;
        finish <= 1'b1;
      end else begin
        count <= count - 18'h00001;
      end
    end else begin
      busy    <= 1'b0;
      powered <= 1'b1;
      count   <= 18'h00000;
    end
  end

endmodule
`default_nettype wire

// File: dmda_core_props.sv
// concurrent checks for the data memory decode and access block
// assumes it is bound to dmda_core and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module dmda_core_props #(
  parameter int unsigned PC_WIDTH   = 13,
  parameter int unsigned ATOMIC_CYC = 20
) (
  input wire logic                CLK,
  input wire logic                RST,
  input wire dmda_pkg::dmda_req_t REQ,
  input wire dmda_pkg::dmda_rsp_t RSP,
  input wire logic                REG_WE,
  input wire logic                IO_WE,
  input wire logic [7:0]          SEL_ADDR,
  input wire logic [7:0]          SEL_WDATA,
  input wire logic                STALL,
  input wire logic                NVM_BUSY,
  input wire logic                ACCESS_FAULT,
  input wire logic [PC_WIDTH-1:0] PROG_WORD_ADDR_MAX
);
  // ****************************************
  // helper logic
  // ****************************************
  logic        pend;      // a request is taken and not yet answered
  logic [15:0] eff;       // effective data address of the request
  logic        ctl_wr;    // write to the nvm control register
  logic        take;      // request accepted at this edge
  int unsigned busy_cnt;  // cycles of programming so far

  assign eff = REQ.port_op ? REQ.addr + 16'h0020 :
               REQ.mode == dmda_pkg::DMDA_MODE_DIRECT ? REQ.addr :
               REQ.mode == dmda_pkg::DMDA_MODE_DISP ? REQ.ptr + {10'h000, REQ.disp} :
               REQ.mode == dmda_pkg::DMDA_MODE_PREDEC ? REQ.ptr - 16'h0001 : REQ.ptr;
  assign take = REQ.valid && !pend && !RSP.done && (REQ.port_op ? REQ.addr < 16'h0040 : eff < 16'h0500);
  assign ctl_wr = REQ.write && eff == 16'h003f;

  // tracks one outstanding request
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend <= 1'b0;
    end else if (take) begin
      pend <= 1'b1;
    end else if (RSP.done) begin
      pend <= 1'b0;
    end
  end

  // programming length, kept through reset like the write itself
  always_ff @(posedge CLK) begin
    if (!NVM_BUSY) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_stall_two;
    (STALL && !RSP.done) ##1 RSP.done;
  endsequence
  sequence s_stall_four;
    (STALL && !RSP.done)[*4] ##1 RSP.done;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_sram_two_cycle: assert property (take && eff >= 16'h0100 |=> STALL && !RSP.done ##1 RSP.done)
    else $error("sram access not answered in two cycles");
  a_plain_one_cycle: assert property (take && eff < 16'h0100 && !(ctl_wr && REQ.wdata[1:0] != 2'b00) |=> RSP.done)
    else $error("register or i/o access not answered next cycle");
  a_nvm_read_stall: assert property (take && ctl_wr && REQ.wdata[1:0] == 2'b01 && !NVM_BUSY |=> s_stall_four)
    else $error("nvm read stall is not four cycles");
  a_nvm_write_stall: assert property ($rose(NVM_BUSY) |-> ($past(STALL) && !$past(RSP.done)) ##0 s_stall_two)
    else $error("nvm write stall is not two cycles");
  a_prog_time_max: assert property (busy_cnt <= ATOMIC_CYC + 2)
    else $error("programming runs too long");
  a_port_refused: assert property (REQ.valid && REQ.port_op && REQ.addr > 16'h003f && !pend |=> ACCESS_FAULT && !RSP.done)
    else $error("port access beyond 0x3f not refused");
  a_predec_ptr: assert property (take && !REQ.port_op && REQ.mode == dmda_pkg::DMDA_MODE_PREDEC |=> RSP.ptr_we && RSP.ptr_new == $past(eff))
    else $error("pre-decrement pointer wrong");
  a_postin_ptr: assert property (take && !REQ.port_op && REQ.mode == dmda_pkg::DMDA_MODE_POSTIN |=> RSP.ptr_we && RSP.ptr_new == $past(REQ.ptr) + 16'h0001)
    else $error("post-increment pointer wrong");
  a_stall_holds: assert property (STALL |-> !REG_WE && !IO_WE && !RSP.done)
    else $error("write-back or done during stall");
  a_port_io_addr: assert property (take && REQ.port_op && REQ.write && REQ.addr < 16'h001f |=> IO_WE && {8'h00, SEL_ADDR} == $past(eff) && SEL_WDATA == $past(REQ.wdata))
    else $error("port write not at port address plus 0x20");
  a_reg_write: assert property (take && REQ.write && eff < 16'h0020 |=> REG_WE && !IO_WE && {8'h00, SEL_ADDR} == $past(eff))
    else $error("register file write misrouted");
  a_word_max: assert property (PROG_WORD_ADDR_MAX == {PC_WIDTH{1'b1}})
    else $error("program word address limit wrong");
endmodule

bind dmda_core dmda_core_props #(.PC_WIDTH(PC_WIDTH), .ATOMIC_CYC(ATOMIC_CYC)) i_dmda_core_props (
  .CLK(CLK), .RST(RST), .REQ(REQ), .RSP(RSP), .REG_WE(REG_WE), .IO_WE(IO_WE), .SEL_ADDR(SEL_ADDR),
  .SEL_WDATA(SEL_WDATA), .STALL(STALL), .NVM_BUSY(NVM_BUSY), .ACCESS_FAULT(ACCESS_FAULT),
  .PROG_WORD_ADDR_MAX(PROG_WORD_ADDR_MAX)
);
`default_nettype wire

// File: dmda_cpu_side.sv
// model of the register file and i/o blocks behind the access sequencer
// assumes read data is looked up combinationally at look_addr, the address of the request now presented
`timescale 1ns/100ps
`default_nettype none
module dmda_cpu_side (
  input  wire logic       clk,
  input  wire logic       reg_we,
  input  wire logic       io_we,
  input  wire logic [7:0] sel_addr,
  input  wire logic [7:0] sel_wdata,
  input  wire logic [7:0] look_addr,  // address of the request now presented
  output logic      [7:0] reg_rdata,
  output logic      [7:0] io_rdata
);
  logic [7:0] store [256];  // registers 0x00-0x1f, i/o 0x20-0xff

  initial begin
    for (int i = 0; i < 256; i++) begin
      store[i] = 8'(i) ^ 8'ha5;
    end
  end

  // write strobes land at the clock edge
  always @(posedge clk) begin
    if (reg_we || io_we) begin
      store[sel_addr] <= sel_wdata;
    end
  end

  assign reg_rdata = store[look_addr];
  assign io_rdata  = store[look_addr];
endmodule
`default_nettype wire

// File: data_memory_decode_access_tb_top.sv
// self-checking bench for the data memory decode and access block
// assumes dmda_pkg, the checker and the cpu side model are compiled first
`timescale 1ns/100ps
`default_nettype none
module data_memory_decode_access_tb_top;
  localparam int ATOM  = 20;  // shortened atomic programming time
  localparam int SPLIT = 10;  // shortened split programming time
  logic clk, rst, reg_we, io_we, io_re, stall, busy, acc_fault;
  logic [7:0] reg_rdata, io_rdata, sel_addr, sel_wdata, d, look;
  logic [dmda_pkg::PC_WIDTH-1:0] pmax;
  dmda_pkg::dmda_req_t req;
  dmda_pkg::dmda_rsp_t rsp;
  int bad_count, compares;
  int model_mem [int];  // expected data space contents
  int nvm [int];        // expected nvm contents
  logic [15:0] p;
  logic [15:0] addrs [8] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h04ff};

  dmda_core #(.ATOMIC_CYC(ATOM), .SPLIT_CYC(SPLIT)) i_dmda_core (
    .CLK(clk), .RST(rst), .REQ(req), .REG_RDATA(reg_rdata), .IO_RDATA(io_rdata), .RSP(rsp),
    .REG_WE(reg_we), .IO_WE(io_we), .IO_RE(io_re), .SEL_ADDR(sel_addr), .SEL_WDATA(sel_wdata),
    .STALL(stall), .NVM_BUSY(busy), .ACCESS_FAULT(acc_fault), .PROG_WORD_ADDR_MAX(pmax));
  dmda_cpu_side i_dmda_cpu_side (.clk(clk), .reg_we(reg_we), .io_we(io_we), .sel_addr(sel_addr),
    .sel_wdata(sel_wdata), .look_addr(look), .reg_rdata(reg_rdata), .io_rdata(io_rdata));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // compare and report
  // ****************************************
  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chkn(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) fail($sformatf("cycles %0d outside %0d..%0d", got, lo, hi));
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one request held until done; lat 0 means derived from the region
  task automatic acc(input logic wr, input logic pt, input logic [1:0] md, input logic [15:0] ad,
                     input logic [15:0] pr, input logic [5:0] ds, input logic [7:0] wd, input int lat);
    logic [15:0] eff;
    logic [15:0] pn;
    logic        pw;
    int          n;
    eff = pt ? ad + 16'h0020 : md == 2'b00 ? ad : md == 2'b01 ? pr + {10'h000, ds} : md == 2'b10 ? pr - 16'h0001 : pr;
    if (lat == 0) lat = (eff >= 16'h0100) ? 2 : 1;
    pw = 1'b0;
    pn = 16'h0000;
    n = 0;
    @(posedge clk);
    req <= '{valid:1'b1, write:wr, port_op:pt, mode:dmda_pkg::dmda_amode_t'(md), addr:ad, ptr:pr, disp:ds, wdata:wd};
    look <= eff[7:0];
    do begin
      @(negedge clk);
      n++;
      if (rsp.ptr_we === 1'b1) begin
        pw = 1'b1;
        pn = rsp.ptr_new;
      end
    end while (rsp.done !== 1'b1 && n < 20);
    @(posedge clk);
    req.valid <= 1'b0;
    chkn(n, lat + 1, lat + 1);
    if (md[1] && !pt) chk1(pw, 1'b1);
    if (md[1] && !pt) chkv(pn, md[0] ? pr + 16'h0001 : pr - 16'h0001);
    if (wr) model_mem[eff] = wd;
    else if (model_mem.exists(eff)) chkv({8'h00, rsp.rdata}, 16'(model_mem[eff]));
  endtask

  // request that must raise a fault
  task automatic bad(input logic pt, input logic [15:0] ad);
    logic f;
    f = 1'b0;
    @(posedge clk);
    req <= '{valid:1'b1, write:1'b0, port_op:pt, mode:dmda_pkg::DMDA_MODE_DIRECT, addr:ad, ptr:16'h0000, disp:6'h00, wdata:8'h00};
    repeat (3) begin
      @(negedge clk);
      f = f | (acc_fault === 1'b1);
    end
    chk1(f, 1'b1);
    @(posedge clk);
    req.valid <= 1'b0;
  endtask

  // address, data, arm and strobe of one nvm write
  task automatic nvm_start(input logic [8:0] a, input logic [7:0] dv, input logic [1:0] m);
    acc(1, 1, 0, 16'h0021, 0, 0, a[7:0], 0);
    acc(1, 1, 0, 16'h0022, 0, 0, {7'h00, a[8]}, 0);
    acc(1, 1, 0, 16'h0020, 0, 0, dv, 0);
    acc(1, 1, 0, 16'h001f, 0, 0, {2'b00, m, 4'h4}, 0);
    acc(1, 1, 0, 16'h001f, 0, 0, {2'b00, m, 4'h2}, 3);
    nvm[a] = (m == 2'b01) ? 8'hff : dv;
    chk1(busy, 1'b1);
  endtask

  // waits for the write strobe to clear by itself
  task automatic nvm_wait(input int lo, input int hi);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chkn(n, lo, hi);
  endtask

  // nvm read trigger, then the data register
  task automatic nvm_rd(input logic [8:0] a);
    acc(1, 1, 0, 16'h0021, 0, 0, a[7:0], 0);
    acc(1, 1, 0, 16'h0022, 0, 0, {7'h00, a[8]}, 0);
    acc(1, 1, 0, 16'h001f, 0, 0, 8'h01, 5);
    model_mem[16'h0040] = nvm[a];
    acc(0, 0, 0, 16'h0040, 0, 0, 0, 0);
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    fail("watchdog expired");
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    req = '0;
    void'($urandom(49));
    for (int i = 0; i < 256; i++) begin
      if (i < 'h3f || i > 'h42) model_mem[i] = i ^ 'ha5;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (addrs[i]) begin
      d = 8'($urandom);
      acc(1, 0, 0, addrs[i], 0, 0, d, 0);
      acc(0, 0, 0, addrs[i], 0, 0, 0, 0);
    end
    p = 16'h0100 + 16'($urandom % 1024);
    acc(1, 0, 0, p, 0, 0, 8'($urandom), 0);
    acc(0, 0, 0, p, 0, 0, 0, 0);
    acc(1, 1, 0, 16'h0005, 0, 0, 8'h3c, 0);
    acc(0, 0, 0, 16'h0025, 0, 0, 0, 0);
    acc(0, 1, 0, 16'h003e, 0, 0, 0, 0);
    p = 16'h0200 + 16'($urandom % 256);
    acc(1, 0, 1, 0, p, 6'h3f, 8'($urandom), 0);
    acc(0, 0, 0, p + 16'h003f, 0, 0, 0, 0);
    acc(1, 0, 2, 0, p, 0, 8'($urandom), 0);
    acc(0, 0, 3, 0, p - 16'h0001, 0, 0, 0);
    bad(1, 16'h0040);
    bad(0, 16'h0500);
    acc(1, 1, 0, 16'h001f, 0, 0, 8'h02, 1);
    @(negedge clk);
    chk1(busy, 1'b0);
    nvm_start(9'h1a5, 8'h5e, 2'b00);
    nvm_wait(ATOM - 4, ATOM + 1);
    nvm_rd(9'h1a5);
    nvm_start(9'h033, 8'h00, 2'b01);
    nvm_wait(SPLIT - 4, SPLIT + 1);
    nvm_rd(9'h033);
    nvm_start(9'h0f0, 8'h96, 2'b00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk1(busy, 1'b1);
    nvm_wait(ATOM - 9, ATOM - 2);
    nvm_rd(9'h0f0);
    chkv(16'(pmax), 16'(2 ** dmda_pkg::PC_WIDTH - 1));
    tally_and_finish();
  end
endmodule
`default_nettype wire
